// file: rtl/csa_pkg.sv
package csa_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned NUM_ALARMS = 4;
	localparam int unsigned NUM_CH = 2;
	localparam int unsigned CH_STRIDE = 3;
	// register addresses of the two channel groups
	localparam logic [15:0] ADDR_CH3_PROCESS_VALUE = 16'hA1DF;
	localparam logic [15:0] ADDR_CH3_COND = 16'hA1E0;
	localparam logic [15:0] ADDR_CH3_ALARM = 16'hA1E1;
	localparam logic [15:0] ADDR_CH4_PROCESS_VALUE = 16'hA1E2;
	localparam logic [15:0] ADDR_CH4_COND = 16'hA1E3;
	localparam logic [15:0] ADDR_CH4_ALARM = 16'hA1E4;
	// alarm word layout: nibble n = {spare, ack, ack_required, active}
	localparam int unsigned ALM_NIBBLE = 4;
	localparam int unsigned ALM_ACTIVE_BIT = 0;
	localparam int unsigned ALM_REQ_BIT = 1;
	localparam int unsigned ALM_ACK_BIT = 2;
	localparam logic [15:0] READ_ZERO = 16'h0000;
	localparam logic [3:0] COND_W_ZERO = 4'h0;

	typedef enum logic [15:0] {
		CSA_GOOD_VALUE = 16'h0000,
		CSA_CHANNEL_OFF = 16'h0001,
		CSA_OVER_RANGE = 16'h0002,
		CSA_UNDER_RANGE = 16'h0003,
		CSA_HARDWARE_ERROR = 16'h0004,
		CSA_RANGING_ERROR = 16'h0005,
		CSA_OVERFLOW = 16'h0006,
		CSA_BAD_VALUE = 16'h0007,
		CSA_NO_DATA = 16'h0008
	} csa_cond_e;

	// measurement side view of one channel
	typedef struct packed {
		logic [15:0] process_value;
		csa_cond_e   condition;
		logic [3:0]  alarm_active;
		logic [3:0]  alarm_raise;
	} csa_chan_s;

	// register access request from the slave protocol engine
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} csa_req_s;
endpackage

// file: rtl/csa_alarm_ch.sv
`timescale 1ns/1ns
module csa_alarm_ch
	import csa_pkg::*;
#(
	parameter int unsigned N = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic         clk_en,
	input  wire logic [N-1:0] alarm_raise,
	input  wire logic [N-1:0] ack_pulse,
	output logic [N-1:0]      ack_required
);
	logic [N-1:0] req_ff;
	logic [N-1:0] nxt_req;

	// a fresh raise in the ack cycle wins, so a new event is not lost; a raise while clk_en is low is dropped
	always_comb begin
		nxt_req = (req_ff & ~ack_pulse) | alarm_raise;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			req_ff <= '0;
		end else if (clk_en) begin
			req_ff <= nxt_req;
		end
	end

	assign ack_required = req_ff;
endmodule

// file: rtl/csa_regs.sv
`timescale 1ns/1ns
// Function
// - The condition word reads the channel's status as an enumerated code 0 to 8.
// - Alarm active flags read at bits 0, 4, 8 and 12 of the alarm word, read only.
// - Ack-required flags read at bits 1, 5, 9 and 13 of the alarm word, read only.
// - Writing one to bit 2, 6, 10 or 14 acknowledges alarm 1, 2, 3 or 4.
// - Each channel group starts with its scaled 16-bit process value, channel 3 at A1DF.
module csa_regs
	import csa_pkg::*;
#(
	parameter int unsigned CHANNELS = NUM_CH,
	parameter int unsigned ALARMS   = NUM_ALARMS
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic         clk_en,
	input  wire csa_chan_s    chan3,
	input  wire csa_chan_s    chan4,
	input  wire csa_req_s     req,
	output logic [15:0]       rdata,
	output logic              rvalid,
	output logic              addr_hit,
	output logic [ALARMS-1:0] ack3_pulse,
	output logic [ALARMS-1:0] ack4_pulse
);
	logic [ALARMS-1:0] req3;
	logic [ALARMS-1:0] req4;
	logic [15:0]       alarm3;
	logic [15:0]       alarm4;
	logic [15:0]       rdata_ff;
	logic [15:0]       nxt_rdata;
	logic              rvalid_ff;
	logic              nxt_rvalid;
	logic [ALARMS-1:0] ack3;
	logic [ALARMS-1:0] ack4;
	logic              hit;

	// pick the write-one ack bits out of the written word
	function automatic logic [NUM_ALARMS-1:0] ack_bits(input logic [15:0] w);
		logic [NUM_ALARMS-1:0] a;
		a = '0;
		for (int i = 0; i < NUM_ALARMS; i++) begin
			a[i] = w[i*ALM_NIBBLE+ALM_ACK_BIT];
		end
		return a;
	endfunction

	// assemble an alarm word; ack bits read zero as they are strobes, spares zero
	function automatic logic [15:0] pack_alarm(input logic [NUM_ALARMS-1:0] act,
		input logic [NUM_ALARMS-1:0] rq);
		logic [15:0] w;
		w = READ_ZERO;
		for (int i = 0; i < NUM_ALARMS; i++) begin
			w[i*ALM_NIBBLE+ALM_ACTIVE_BIT] = act[i];
			w[i*ALM_NIBBLE+ALM_REQ_BIT]    = rq[i];
		end
		return w;
	endfunction

	// ack strobes, one cycle, only for a write to the matching alarm word
	always_comb begin
		ack3 = '0;
		ack4 = '0;
		if (req.wr && clk_en) begin
			if (req.addr == ADDR_CH3_ALARM) begin
				ack3 = ack_bits(req.wdata);
			end else if (req.addr == ADDR_CH4_ALARM) begin
				ack4 = ack_bits(req.wdata);
			end
		end
	end

	csa_alarm_ch #(
		.N(ALARMS)
	) u_alarm3 (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.clk_en       (clk_en),
		.alarm_raise  (chan3.alarm_raise),
		.ack_pulse    (ack3),
		.ack_required (req3)
	);

	csa_alarm_ch #(
		.N(ALARMS)
	) u_alarm4 (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.clk_en       (clk_en),
		.alarm_raise  (chan4.alarm_raise),
		.ack_pulse    (ack4),
		.ack_required (req4)
	);

	assign alarm3 = pack_alarm(chan3.alarm_active, req3);
	assign alarm4 = pack_alarm(chan4.alarm_active, req4);

	// read decode; unmapped addresses answer zero with addr_hit low
	always_comb begin
		nxt_rdata = READ_ZERO;
		hit = 1'b1;
		if (req.addr == ADDR_CH3_PROCESS_VALUE) begin
			nxt_rdata = chan3.process_value;
		end else if (req.addr == ADDR_CH3_COND) begin
			nxt_rdata = chan3.condition;
		end else if (req.addr == ADDR_CH3_ALARM) begin
			nxt_rdata = alarm3;
		end else if (req.addr == ADDR_CH4_PROCESS_VALUE) begin
			nxt_rdata = chan4.process_value;
		end else if (req.addr == ADDR_CH4_COND) begin
			nxt_rdata = chan4.condition;
		end else if (req.addr == ADDR_CH4_ALARM) begin
			nxt_rdata = alarm4;
		end else begin
			hit = 1'b0;
		end
		if (!req.rd) begin
			nxt_rdata = rdata_ff;
		end
		nxt_rvalid = req.rd;
	end

	// read data registered so the master sees a stable word
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_ff  <= READ_ZERO;
			rvalid_ff <= 1'b0;
		end else if (clk_en) begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign rdata      = rdata_ff;
	assign rvalid     = rvalid_ff;
	assign addr_hit   = hit;
	assign ack3_pulse = ack3;
	assign ack4_pulse = ack4;
endmodule

// file: testbench/csa_chk_checker.sv
`timescale 1ns/1ns
module csa_chk
	import csa_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        clk_en,
	input wire csa_chan_s   chan3,
	input wire csa_chan_s   chan4,
	input wire csa_req_s    req,
	input wire logic [15:0] rdata,
	input wire logic        rvalid,
	input wire logic        addr_hit,
	input wire logic [3:0]  ack3_pulse,
	input wire logic [3:0]  ack4_pulse
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// a read only counts on an enabled clock
	wire logic rd_go = req.rd && clk_en;
	rd_answer_a: assert property (rvalid == $past(rd_go)) else $error("rvalid");
	value_read_a: assert property (rd_go && req.addr == ADDR_CH3_PROCESS_VALUE |=>
		rdata == $past(chan3.process_value)) else $error("value");
	cond_read_a: assert property (rd_go && req.addr == ADDR_CH4_COND |=>
		rdata == $past(chan4.condition)) else $error("cond");
	active_read_a: assert property (rd_go && req.addr == ADDR_CH3_ALARM |=>
		{rdata[12], rdata[8], rdata[4], rdata[0]} == $past(chan3.alarm_active)) else $error("act");
	req_set_a: assert property (chan3.alarm_raise[1] && clk_en ##2
		rd_go && req.addr == ADDR_CH3_ALARM |=> rdata[5]) else $error("req");
	// strobe is combinational, so it must match the write in the same cycle
	ack_strobe_a: assert property (ack3_pulse == ((clk_en && req.wr &&
		req.addr == ADDR_CH3_ALARM) ? {req.wdata[14], req.wdata[10], req.wdata[6],
		req.wdata[2]} : 4'h0)) else $error("ack");
	ack4_strobe_a: assert property (ack4_pulse == ((clk_en && req.wr &&
		req.addr == ADDR_CH4_ALARM) ? {req.wdata[14], req.wdata[10], req.wdata[6],
		req.wdata[2]} : 4'h0)) else $error("ack4");
	map_hit_a: assert property (addr_hit ==
		(req.addr inside {[ADDR_CH3_PROCESS_VALUE:ADDR_CH4_ALARM]})) else $error("hit");
endmodule

// file: testbench/csa_master.sv
`timescale 1ns/1ns
module csa_master
	import csa_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rvalid,
	input wire logic [15:0] rdata,
	output csa_req_s        req
);
	initial req = '0;
	// one-cycle read strobe, then a bounded wait for rvalid
	task rd(input logic [15:0] a, output logic [15:0] d, output bit ok);
		ok = 0;
		@(posedge clk_sys) req <= '{1'b1, 1'b0, a, 16'h0000};
		@(posedge clk_sys) req <= '0;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1 ok = rvalid === 1'b1;
			d = rdata;
			if (!ok) @(posedge clk_sys);
		end
	endtask
	task wr(input logic [15:0] a, w);
		@(posedge clk_sys) req <= '{1'b0, 1'b1, a, w};
		@(posedge clk_sys) req <= '0;
	endtask
endmodule

// file: testbench/csa_regs_tb.sv
`timescale 1ns/1ns
module csa_regs_tb;
	import csa_pkg::*;
	logic        clk_sys = 0;
	logic        reset = 1;
	logic        clk_en = 1;
	csa_chan_s   chan3 = '0;
	csa_chan_s   chan4 = '0;
	csa_req_s    req;
	logic [15:0] rdata;
	logic        rvalid;
	logic        addr_hit;
	logic [3:0]  ack3_pulse;
	logic [3:0]  ack4_pulse;
	int          mismatches = 0;
	int          n_checks = 0;
	logic [15:0] d;
	bit          ok;
	csa_regs dut (.*);
	csa_master m (.clk_sys, .rvalid, .rdata, .req);
	initial forever #25 clk_sys = ~clk_sys;
	task conclude;
		$display("mismatches %0d checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// a lost answer ends the run at once
	task rd_chk(input logic [15:0] a, e, input string nm);
		m.rd(a, d, ok);
		if (!ok) begin
			mismatches++;
			conclude();
		end
		n_checks++;
		if (d !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", nm, e, d);
		end
	endtask
	task t_codes;
		for (int c = 0; c < 9; c++) begin
			@(posedge clk_sys) chan4.condition <= csa_cond_e'(c);
			chan3.process_value <= 16'hA500 + c[15:0];
			rd_chk(ADDR_CH4_COND, c[15:0], "cond");
			rd_chk(ADDR_CH3_PROCESS_VALUE, 16'hA500 + c[15:0], "value");
		end
	endtask
	// ack 1 and 3 with spare bits set too, 2 and 4 must stay pending
	task t_alarm;
		@(posedge clk_sys) chan3.alarm_active <= 4'h5;
		chan3.alarm_raise <= 4'hF;
		@(posedge clk_sys) chan3.alarm_raise <= 4'h0;
		rd_chk(ADDR_CH3_ALARM, 16'h2323, "raised");
		m.wr(ADDR_CH3_ALARM, 16'h8C8C);
		rd_chk(ADDR_CH3_ALARM, 16'h2121, "acked");
		rd_chk(16'hA1E5, 16'h0000, "unmapped");
	endtask
	// channel 4 acks, one of them sent while the clock enable is low
	task t_freeze;
		@(posedge clk_sys) chan4.alarm_raise <= 4'h6;
		chan4.process_value <= 16'h5AC3;
		@(posedge clk_sys) chan4.alarm_raise <= 4'h0;
		clk_en <= 1'b0;
		m.wr(ADDR_CH4_ALARM, 16'h4444);
		@(posedge clk_sys) clk_en <= 1'b1;
		rd_chk(ADDR_CH4_ALARM, 16'h0220, "frozen");
		m.wr(ADDR_CH4_ALARM, 16'h4444);
		rd_chk(ADDR_CH4_ALARM, 16'h0000, "acked4");
		rd_chk(ADDR_CH4_PROCESS_VALUE, 16'h5AC3, "value4");
		rd_chk(ADDR_CH3_COND, 16'h0000, "cond3");
	endtask
	// reset in mid-run drops pending acks but not the active levels
	task t_reset;
		@(posedge clk_sys) reset <= 1'b1;
		@(posedge clk_sys) reset <= 1'b0;
		rd_chk(ADDR_CH3_ALARM, 16'h0101, "reset");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 0;
		t_codes();
		t_alarm();
		t_freeze();
		t_reset();
		conclude();
	end
endmodule
bind csa_regs csa_chk u_chk (.*);
